// ### src/wes_consts.svh
// constants for the wait-for-event sleep controller: offsets, fields, resets
// assumes it is included by the design file by its bare name
// Functional notes
// - one event flag bit per processor
// - reset clears the event flag
// - wake events and exception return set flag
// - wait-for-event with flag set: clear, complete
// - software cannot read or write the flag
// - flag clear: may sleep until wake or reset
// - any send-event counts as a wake event
// - new pending exception wakes when enabled
// - preempting asynchronous exception is a wake event
// - debug event wakes only with debug enabled
// - send-event sets flag of every processor
// - restart after suspension leaves flag unchanged
// - wait-for-interrupt wakes on preempt, mask ignored
// - debug event or extra source also wakes
// - on completion take exception or resume
// - at top priority only reset or halt
// - suspension stops execution and bus activity
// - signal bus idle to power controller
// - optional drain of memory activity first
// - pend-as-wakeup bit counts masked interrupts too
`ifndef WES_CONSTS_SVH
`define WES_CONSTS_SVH

`define WES_OFF_CTRL 8'h00
`define WES_OFF_STATUS 8'h04
`define WES_OFF_WAKECNT 8'h08

`define WES_CTRL_PEND_BIT 0
`define WES_CTRL_DRAIN_BIT 1
`define WES_CTRL_NOP_BIT 2
`define WES_CTRL_RESET 3'h0

`define WES_ST_SLEEP_BIT 0
`define WES_ST_WFI_BIT 1
`define WES_ST_DRAIN_BIT 2
`define WES_ST_IDLE_BIT 3

`endif

// ### src/wes_pkg.sv
// types shared by the wait-for-event sleep controller
// needs nothing beside it; it does not include wes_consts.svh
package wes_pkg;

    // controller states
    typedef enum logic [1:0] {
        WES_RUN,
        WES_DRAIN,
        WES_WFE_SLEEP,
        WES_WFI_SLEEP
    } wes_state_e;

    // wake sources from the core and the system
    typedef struct packed {
        logic sev_local;
        logic sev_remote;
        logic pend_new;
        logic preempt_async;
        logic dbg_event;
        logic exc_return;
    } wes_wake_s;

endpackage

// ### src/wes_top.sv
// sleep and wakeup control for the wait-for-event and wait-for-interrupt hints
// assumes a core that pulses one instruction strobe per hint and stalls on STALL_OUT,
// peers that toggle a send-event line, and an APB master for the control registers
`timescale 1ns/10ps
`include "wes_consts.svh"

module wes_top #(
    parameter int CNT_W = 16
) (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic WFE_INSTR_IN,
    input wire logic WFI_INSTR_IN,
    input wire logic SEV_INSTR_IN,
    input wire logic SEV_PEER_TOGGLE_IN,
    input wire logic EXC_RETURN_IN,
    input wire logic PEND_NEW_IN,
    input wire logic PREEMPT_ASYNC_IN,
    input wire logic PREEMPT_MASKED_IN,
    input wire logic NMI_PRIO_IN,
    input wire logic DEBUG_EN_IN,
    input wire logic DEBUG_EVENT_IN,
    input wire logic DEBUG_HALT_IN,
    input wire logic IMPL_WAKE_IN,
    input wire logic BUS_ACTIVE_IN,
    output logic SEV_TOGGLE_OUT,
    output logic DONE_OUT,
    output logic TAKE_EXC_OUT,
    output logic STALL_OUT,
    output logic SLEEPING_OUT,
    output logic BUS_IDLE_OUT
);

    // ******************************************
    // declarations
    // ******************************************
    wes_pkg::wes_state_e state_r;
    wes_pkg::wes_state_e state_nxt;
    wes_pkg::wes_wake_s wake;
    logic event_flag_r;
    logic event_flag_nxt;
    logic [2:0] ctrl_r;
    logic [CNT_W-1:0] wake_cnt_r;
    logic sev_meta_r;
    logic sev_sync_r;
    logic sev_last_r;
    logic sev_tog_r;
    logic done_r;
    logic take_r;
    logic done_nxt;
    logic take_nxt;
    logic [31:0] prdata_r;
    logic ev_set;
    logic wfe_wake;
    logic wfi_wake;
    logic in_run;
    logic asleep;
    logic leave_sleep;
    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic hit_ctrl;
    logic hit_status;
    logic hit_cnt;
    logic mapped;
    logic [31:0] rd_word;
    logic [3:0] status_word;

    // address match against one register offset
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // ******************************************
    // peer send-event crossing
    // ******************************************
    // the peer line toggles once per send-event; two flops, then edge compare;
    // the flops keep tracking through reset, so a line that a peer left high
    // gives no false edge after release
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN || CE_IN) begin
            sev_meta_r <= SEV_PEER_TOGGLE_IN;
            sev_sync_r <= sev_meta_r;
            sev_last_r <= sev_sync_r;
        end
    end

    // ******************************************
    // wake source decode
    // ******************************************
    // gather the sources; pending and debug events are gated by their enables
    assign wake.sev_local = SEV_INSTR_IN;
    assign wake.sev_remote = sev_sync_r ^ sev_last_r;
    assign wake.pend_new = PEND_NEW_IN & ctrl_r[`WES_CTRL_PEND_BIT];
    assign wake.preempt_async = PREEMPT_ASYNC_IN;
    assign wake.dbg_event = DEBUG_EVENT_IN & DEBUG_EN_IN;
    assign wake.exc_return = EXC_RETURN_IN;

    // wait-for-event wakes on every source except exception return
    assign wfe_wake = wake.sev_local | wake.sev_remote | wake.pend_new
                    | wake.preempt_async | wake.dbg_event;
    // the flag is set by any wake event and by exception return
    assign ev_set = wfe_wake | wake.exc_return;

    // at top priority nothing preempts, so only a halt forces completion
    assign wfi_wake = NMI_PRIO_IN ? DEBUG_HALT_IN :
                      (wake.preempt_async | wake.dbg_event | IMPL_WAKE_IN
                       | DEBUG_HALT_IN);

    assign in_run = (state_r == wes_pkg::WES_RUN);
    assign asleep = (state_r == wes_pkg::WES_WFE_SLEEP)
                  | (state_r == wes_pkg::WES_WFI_SLEEP);

    // ******************************************
    // event flag
    // ******************************************
    // a set in the same cycle as the wait-for-event clear wins; restart
    // after a suspension leaves the flag as the waking event left it
    assign event_flag_nxt = ev_set ? 1'b1 :
                            (in_run & WFE_INSTR_IN) ? 1'b0 :
                            event_flag_r;

    // one hidden bit, never mapped on the bus
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            event_flag_r <= 1'b0;
        end else if (CE_IN) begin
            event_flag_r <= event_flag_nxt;
        end
    end

    // ******************************************
    // sleep state machine
    // ******************************************
    // decides suspension, completion and whether an exception is taken
    always_comb begin
        state_nxt = state_r;
        done_nxt = 1'b0;
        take_nxt = 1'b0;
        case (state_r)
            wes_pkg::WES_RUN: begin
                if (WFE_INSTR_IN) begin
                    if (event_flag_r || wfe_wake || ctrl_r[`WES_CTRL_NOP_BIT]) begin
                        done_nxt = 1'b1;
                    end else begin
                        state_nxt = wes_pkg::WES_WFE_SLEEP;
                    end
                end else if (WFI_INSTR_IN) begin
                    if (wfi_wake || ctrl_r[`WES_CTRL_NOP_BIT]) begin
                        done_nxt = 1'b1;
                        take_nxt = PREEMPT_MASKED_IN;
                    end else if (ctrl_r[`WES_CTRL_DRAIN_BIT] && BUS_ACTIVE_IN) begin
                        state_nxt = wes_pkg::WES_DRAIN;
                    end else begin
                        state_nxt = wes_pkg::WES_WFI_SLEEP;
                    end
                end
            end
            wes_pkg::WES_DRAIN: begin
                if (wfi_wake) begin
                    state_nxt = wes_pkg::WES_RUN;
                    done_nxt = 1'b1;
                    take_nxt = PREEMPT_MASKED_IN;
                end else if (!BUS_ACTIVE_IN) begin
                    state_nxt = wes_pkg::WES_WFI_SLEEP;
                end
            end
            wes_pkg::WES_WFE_SLEEP: begin
                if (wfe_wake) begin
                    state_nxt = wes_pkg::WES_RUN;
                    done_nxt = 1'b1;
                end
            end
            wes_pkg::WES_WFI_SLEEP: begin
                if (wfi_wake) begin
                    state_nxt = wes_pkg::WES_RUN;
                    done_nxt = 1'b1;
                    take_nxt = PREEMPT_MASKED_IN;
                end
            end
            default: begin
                state_nxt = wes_pkg::WES_RUN;
            end
        endcase
    end

    assign leave_sleep = asleep & (state_nxt == wes_pkg::WES_RUN);

    // state, completion strobes and the count of wakes from sleep
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            state_r <= wes_pkg::WES_RUN;
            done_r <= 1'b0;
            take_r <= 1'b0;
            wake_cnt_r <= '0;
        end else if (CE_IN) begin
            state_r <= state_nxt;
            done_r <= done_nxt;
            take_r <= take_nxt;
            wake_cnt_r <= wake_cnt_r + CNT_W'(leave_sleep);
        end
    end

    // ******************************************
    // send-event broadcast
    // ******************************************
    // each local send-event flips the line that all peers watch
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            sev_tog_r <= 1'b0;
        end else if (CE_IN && SEV_INSTR_IN) begin
            sev_tog_r <= ~sev_tog_r;
        end
    end

    // ******************************************
    // APB slave
    // ******************************************
    // zero-wait slave; read data is captured in the setup cycle
    assign setup_ph = PSEL_IN & ~PENABLE_IN;
    assign access_ph = PSEL_IN & PENABLE_IN & CE_IN;
    assign hit_ctrl = reg_hit(PADDR_IN, `WES_OFF_CTRL);
    assign hit_status = reg_hit(PADDR_IN, `WES_OFF_STATUS);
    assign hit_cnt = reg_hit(PADDR_IN, `WES_OFF_WAKECNT);
    assign mapped = hit_ctrl | hit_status | hit_cnt;
    assign wr_ctrl = access_ph & PWRITE_IN & hit_ctrl & PSTRB_IN[0];

    // status shows the controller's own state, never the event flag
    assign status_word[`WES_ST_SLEEP_BIT] = asleep;
    assign status_word[`WES_ST_WFI_BIT] = (state_r == wes_pkg::WES_WFI_SLEEP);
    assign status_word[`WES_ST_DRAIN_BIT] = (state_r == wes_pkg::WES_DRAIN);
    assign status_word[`WES_ST_IDLE_BIT] = BUS_IDLE_OUT;

    // read selection; unmapped reads return zero
    assign rd_word = hit_ctrl ? {29'h0, ctrl_r} :
                     hit_status ? {28'h0, status_word} :
                     hit_cnt ? 32'(wake_cnt_r) : 32'h0;

    // control register and read data capture
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            ctrl_r <= `WES_CTRL_RESET;
            prdata_r <= 32'h0;
        end else if (CE_IN) begin
            if (wr_ctrl) begin
                ctrl_r <= PWDATA_IN[2:0];
            end
            if (setup_ph) begin
                prdata_r <= rd_word;
            end
        end
    end

    assign PREADY_OUT = CE_IN; // frozen transfers wait
    assign PSLVERR_OUT = access_ph & ~mapped;
    assign PRDATA_OUT = prdata_r;

    // ******************************************
    // outputs to core and power controller
    // ******************************************
    assign SEV_TOGGLE_OUT = sev_tog_r;
    assign DONE_OUT = done_r;
    assign TAKE_EXC_OUT = take_r;
    assign STALL_OUT = asleep | (state_r == wes_pkg::WES_DRAIN);
    assign SLEEPING_OUT = asleep;
    assign BUS_IDLE_OUT = asleep & ~BUS_ACTIVE_IN;

    // ******************************************
    // assertions
    // ******************************************
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    // entry to wait-for-interrupt sleep with no wake pending
    sequence s_wfi_enter;
        CE_IN && in_run && WFI_INSTR_IN && !wfi_wake
        && !ctrl_r[`WES_CTRL_NOP_BIT] && !BUS_ACTIVE_IN;
    endsequence

    // wake in wait-for-interrupt sleep; the completion strobe follows it
    sequence s_wfi_wake;
        CE_IN && state_r == wes_pkg::WES_WFI_SLEEP && wfi_wake;
    endsequence

    a_flag_reset: assert property (
        @(posedge CLK_IN) disable iff (1'b0) !RSTN_IN |=> !event_flag_r)
        else $error("event flag not cleared by reset");

    a_flag_set: assert property (
        CE_IN && ev_set |=> event_flag_r)
        else $error("event flag missed a wake event");

    a_wfe_fast: assert property (
        CE_IN && in_run && WFE_INSTR_IN && event_flag_r && !ev_set
        |=> DONE_OUT && !event_flag_r && !SLEEPING_OUT)
        else $error("wait-for-event with flag set did not return at once");

    a_wfe_sleep: assert property (
        CE_IN && in_run && WFE_INSTR_IN && !event_flag_r && !wfe_wake
        && !ctrl_r[`WES_CTRL_NOP_BIT] |=> SLEEPING_OUT && STALL_OUT && !DONE_OUT)
        else $error("wait-for-event with flag clear did not suspend");

    a_sev_toggle: assert property (
        CE_IN && SEV_INSTR_IN |=> SEV_TOGGLE_OUT != $past(SEV_TOGGLE_OUT))
        else $error("send-event not broadcast");

    a_wfi_cycle: assert property (
        s_wfi_enter |=> SLEEPING_OUT && STALL_OUT && !DONE_OUT)
        else $error("wait-for-interrupt did not suspend");

    a_wfi_wake: assert property (
        s_wfi_wake |=> DONE_OUT && !SLEEPING_OUT)
        else $error("wait-for-interrupt wake did not complete");

    // a wake from wait-for-event sleep completes and leaves the flag set
    a_wfe_wake: assert property (
        CE_IN && state_r == wes_pkg::WES_WFE_SLEEP && wfe_wake
        |=> DONE_OUT && !SLEEPING_OUT && event_flag_r)
        else $error("wait-for-event wake wrong");

    // completion is only ever shown with the core running again
    a_done_run: assert property (
        DONE_OUT |-> !STALL_OUT && !SLEEPING_OUT)
        else $error("completion shown while stalled");

    a_wfi_take: assert property (
        s_wfi_wake |=> DONE_OUT && (TAKE_EXC_OUT == $past(PREEMPT_MASKED_IN)))
        else $error("wrong exception decision on completion");

    a_nmi_hold: assert property (
        CE_IN && state_r == wes_pkg::WES_WFI_SLEEP && NMI_PRIO_IN
        && !DEBUG_HALT_IN |=> SLEEPING_OUT && !DONE_OUT)
        else $error("top-priority wait-for-interrupt woke without halt");

    a_bus_idle: assert property (
        BUS_IDLE_OUT == (SLEEPING_OUT && !BUS_ACTIVE_IN))
        else $error("bus idle indication wrong while asleep");

    a_drain_hold: assert property (
        CE_IN && state_r == wes_pkg::WES_DRAIN && BUS_ACTIVE_IN && !wfi_wake
        |=> STALL_OUT && !SLEEPING_OUT)
        else $error("drain left before bus went quiet");

endmodule

// ### dv/wes_peer_model.sv
// far-side model: one peer processor and an external power controller
// assumes the bench requests peer send-events and bus traffic as levels
`timescale 1ns/10ps

module wes_peer_model (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic busy_in,
    input wire logic bus_idle_in,
    output logic toggle_out,
    output logic bus_active_out,
    output int idle_cnt_out
);
    logic tog = 1'b0;
    int cnt = 0;

    // peer broadcast: one toggle per send-event, off the clock grid
    always @(posedge send_in) begin
        #3.3 tog = ~tog;
    end
    // outstanding bus traffic as the power controller sees it
    assign toggle_out = tog;
    assign bus_active_out = busy_in;
    assign idle_cnt_out = cnt;
    // power controller counts the cycles reported idle
    always @(posedge clk_in) begin
        if (bus_idle_in === 1'b1) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ### dv/wes_top_tb.sv
// self-checking bench for the wait-for-event sleep controller
// assumes wes_pkg, wes_top and wes_peer_model are compiled before it
`timescale 1ns/10ps

`define CHK(nm, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end

module wes_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic wait_for_event_instr = 1'b0, wait_for_interrupt_instr = 1'b0, impl = 1'b0, halt = 1'b0;
    logic dbg_en = 1'b0, nmi = 1'b0, masked = 1'b0, busy = 1'b0;
    wes_pkg::wes_wake_s w = '0;
    logic [31:0] prdata;
    logic pready, pslverr, tog_out, done, take, stall, sleeping, bus_idle, peer_tog, bus_act;
    int idle_cnt;
    int n_errors = 0;
    int check_count = 0;
    logic tog_exp = 1'b0;
    logic exp_t;
    logic [32:0] exp_r;
    logic [15:0] rnd = 16'h8ADF;
    logic tq[$];
    logic [32:0] rq[$];

    wes_top #(.CNT_W(16)) DUT (
        .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .WFE_INSTR_IN(wait_for_event_instr), .WFI_INSTR_IN(wait_for_interrupt_instr), .SEV_INSTR_IN(w.sev_local),
        .SEV_PEER_TOGGLE_IN(peer_tog), .EXC_RETURN_IN(w.exc_return),
        .PEND_NEW_IN(w.pend_new), .PREEMPT_ASYNC_IN(w.preempt_async),
        .PREEMPT_MASKED_IN(masked), .NMI_PRIO_IN(nmi), .DEBUG_EN_IN(dbg_en),
        .DEBUG_EVENT_IN(w.dbg_event), .DEBUG_HALT_IN(halt), .IMPL_WAKE_IN(impl),
        .BUS_ACTIVE_IN(bus_act), .SEV_TOGGLE_OUT(tog_out), .DONE_OUT(done),
        .TAKE_EXC_OUT(take), .STALL_OUT(stall), .SLEEPING_OUT(sleeping),
        .BUS_IDLE_OUT(bus_idle)
    );

    wes_peer_model PEER (
        .clk_in(clk), .send_in(w.sev_remote), .busy_in(busy), .bus_idle_in(bus_idle),
        .toggle_out(peer_tog), .bus_active_out(bus_act), .idle_cnt_out(idle_cnt)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // result monitor: the oldest note is compared as each result shows
    always @(posedge clk) begin
        if (done === 1'b1) begin
            exp_t = (tq.size() > 0) ? tq.pop_front() : 1'bx;
            `CHK("take_exc", exp_t, take)
        end
        if (psel && pen && pready === 1'b1 && !pwr) begin
            exp_r = rq.pop_front();
            `CHK("apb read", exp_r, {pslverr, prdata})
        end
    end

    // ****************
    // stimulus tasks
    // ****************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask

    // issue one hint; sleeps says whether the core must stay stalled
    task automatic hint(input logic is_wfi, input logic sleeps, input logic tk);
        tq.push_back(tk);
        @(posedge clk);
        wait_for_interrupt_instr <= is_wfi;
        wait_for_event_instr <= !is_wfi;
        @(posedge clk);
        wait_for_interrupt_instr <= 1'b0;
        wait_for_event_instr <= 1'b0;
        #1;
        `CHK("stall", sleeps, stall)
        `CHK("done", !sleeps, done)
    endtask

    task automatic pulse(input wes_pkg::wes_wake_s p);
        @(posedge clk);
        w <= p;
        @(posedge clk);
        w <= '0;
        #1;
    endtask

    task automatic wake();
        int n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("woken", 1'b1, done)
        `CHK("asleep", 1'b0, sleeping)
    endtask

    task automatic stay();
        repeat (4) @(posedge clk);
        #1;
        `CHK("still asleep", 1'b1, sleeping)
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    // ****************
    // test sequence
    // ****************
    initial begin
        int i0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("stall", 1'b0, stall)
        `CHK("toggle", 1'b0, tog_out)
        rd(8'h00, 33'h0);
        rd(8'h08, 33'h0);
        rd(8'h0C, 33'h1_0000_0000);
        apb(1'b1, 8'h00, {rnd, 16'hFFFF}, 4'hF);
        rd(8'h00, 33'h7);
        apb(1'b1, 8'h00, 32'h0, 4'h0);
        rd(8'h00, 33'h7);
        apb(1'b1, 8'h04, 32'hF, 4'hF);
        rd(8'h04, 33'h0);
        apb(1'b1, 8'h00, 32'h0, 4'hF);
        rnd = lfsr(rnd);
        $display("test registers done");
        hint(1'b0, 1'b1, 1'b0);
        stay();
        rd(8'h04, 33'h9);
        repeat (rnd[2:0]) @(posedge clk);
        pulse(6'h10);
        wake();
        hint(1'b0, 1'b0, 1'b0);
        hint(1'b0, 1'b1, 1'b0);
        pulse(6'h02);
        pulse(6'h08);
        stay();
        @(posedge clk);
        dbg_en <= 1'b1;
        pulse(6'h02);
        wake();
        hint(1'b0, 1'b0, 1'b0);
        hint(1'b0, 1'b1, 1'b0);
        apb(1'b1, 8'h00, 32'h1, 4'hF);
        pulse(6'h08);
        wake();
        hint(1'b0, 1'b0, 1'b0);
        hint(1'b0, 1'b1, 1'b0);
        pulse(6'h04);
        wake();
        hint(1'b0, 1'b0, 1'b0);
        pulse(6'h20);
        tog_exp = ~tog_exp;
        `CHK("sev toggle", tog_exp, tog_out)
        hint(1'b0, 1'b0, 1'b0);
        pulse(6'h01);
        hint(1'b0, 1'b0, 1'b0);
        rd(8'h08, 33'h4);
        // mid-run reset with the flag set and the peer line left high
        pulse(6'h01);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h08, 33'h0);
        hint(1'b0, 1'b1, 1'b0);
        pulse(6'h04);
        wake();
        $display("test wait for event done");
        @(posedge clk);
        masked <= 1'b1;
        i0 = idle_cnt;
        hint(1'b1, 1'b1, 1'b1);
        stay();
        `CHK("idle cycles", 1'b1, (idle_cnt - i0) >= 4)
        rd(8'h04, 33'hB);
        // a frozen block must not see a wake
        @(posedge clk);
        ce <= 1'b0;
        pulse(6'h04);
        stay();
        @(posedge clk);
        ce <= 1'b1;
        pulse(6'h04);
        wake();
        @(posedge clk);
        masked <= 1'b0;
        hint(1'b1, 1'b1, 1'b0);
        pulse(6'h04);
        wake();
        @(posedge clk);
        nmi <= 1'b1;
        hint(1'b1, 1'b1, 1'b0);
        pulse(6'h04);
        stay();
        @(posedge clk);
        halt <= 1'b1;
        wake();
        @(posedge clk);
        halt <= 1'b0;
        nmi <= 1'b0;
        hint(1'b1, 1'b1, 1'b0);
        @(posedge clk);
        impl <= 1'b1;
        wake();
        @(posedge clk);
        impl <= 1'b0;
        hint(1'b1, 1'b1, 1'b0);
        pulse(6'h02);
        wake();
        apb(1'b1, 8'h00, 32'h2, 4'hF);
        @(posedge clk);
        busy <= 1'b1;
        hint(1'b1, 1'b1, 1'b0);
        `CHK("drain not asleep", 1'b0, sleeping)
        rd(8'h04, 33'h4);
        @(posedge clk);
        busy <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("asleep after drain", 1'b1, sleeping)
        @(posedge clk);
        impl <= 1'b1;
        wake();
        @(posedge clk);
        impl <= 1'b0;
        apb(1'b1, 8'h00, 32'h4, 4'hF);
        hint(1'b1, 1'b0, 1'b0);
        hint(1'b0, 1'b0, 1'b0);
        // let the monitor take the last completion before closing
        repeat (2) @(posedge clk);
        `CHK("notes left", 0, tq.size())
        $display("test wait for interrupt done");
        results();
    end
endmodule
